// file: design/stm_pkg.sv
// Shared constants, encodings and the configuration record of the trigger matcher.
// Assumes one configuration clock (mclk) and one acquisition clock for the observed bus.
package stm_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_CHAN = 20;      // C1..C4 then D0..D15
	localparam int SRC_W = 5;
	localparam int NUM_SRC = 7;
	localparam int SRC_SCL = 0;
	localparam int SRC_SDA = 1;
	localparam int SRC_SCLK = 2;
	localparam int SRC_HOUT = 3;
	localparam int SRC_HIN = 4;
	localparam int SRC_SEL = 5;
	localparam int SRC_ISEL = 6;
	localparam int SPI_BITS = 96;
	localparam int SPI_LEN_W = 7;
	localparam int TMO_W = 17;
	localparam int I2C_DLEN_MAX = 12;

	// ----------------------------------------------------------------
	// Timing on the acquisition clock
	// ----------------------------------------------------------------
	localparam int ACQ_PERIOD_NS = 64;
	localparam int TMO_MIN_NS = 100;
	localparam int TMO_MAX_NS = 5000000;
	localparam int TMO_MIN_CYC = (TMO_MIN_NS + ACQ_PERIOD_NS - 1) / ACQ_PERIOD_NS;
	localparam int TMO_MAX_CYC = TMO_MAX_NS / ACQ_PERIOD_NS;

	// ----------------------------------------------------------------
	// Bus constants
	// ----------------------------------------------------------------
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
	localparam logic [3:0] I2C_ACK_SLOT = 4'h8;
	localparam logic [1:0] I2C_BYTE_SAT = 2'h2;

	typedef enum logic {PROTO_I2C, PROTO_SPI} stm_proto_t;
	typedef enum logic {COND_MEM_FRAME, COND_ADDR_LEN} stm_cond_t;
	typedef enum logic [1:0] {QUAL_EQUAL, QUAL_GREATER, QUAL_LESS} stm_qual_t;
	typedef enum logic [1:0] {DIR_READ, DIR_WRITE, DIR_EITHER} stm_dir_t;
	typedef enum logic {ADDR_SEVEN_BIT, ADDR_TEN_BIT} stm_awidth_t;
	typedef enum logic {EDGE_RISING, EDGE_FALLING} stm_edge_t;
	typedef enum logic [1:0] {FRAME_PLAIN, FRAME_INVERTED, FRAME_TIMEOUT} stm_frame_t;
	typedef enum logic {I2C_IDLE, I2C_XFER} stm_i2c_state_t;

	typedef struct packed {
		stm_proto_t proto;
		stm_cond_t cond;
		stm_qual_t qual;
		stm_dir_t dir;
		stm_awidth_t awidth;
		logic [9:0] addr;
		logic [7:0] data;
		logic [3:0] dlen;
		stm_edge_t edge_sel;
		stm_frame_t frame;
		logic line_in;
		logic [TMO_W-1:0] tmo;
		logic [SPI_LEN_W-1:0] slen;
		logic [SPI_BITS-1:0] pat;
		logic [SPI_BITS-1:0] care;
		logic [NUM_SRC-1:0][SRC_W-1:0] src;
	} stm_cfg_t;

	localparam stm_cfg_t CFG_RESET = '0;

endpackage : stm_pkg

// file: design/stm_route_if.sv
// Carries the synchronised channel bus, the source selections and the picked lines.
// Assumes both ends sit on the acquisition clock.
interface stm_route_if #(
	parameter int NCH = stm_pkg::NUM_CHAN,
	parameter int NSEL = stm_pkg::NUM_SRC,
	parameter int SW = stm_pkg::SRC_W
) ();
	logic [NCH-1:0] chans;
	logic [NSEL-1:0][SW-1:0] sel;
	logic [NSEL-1:0] pick;
	modport mux (input chans, input sel, output pick);
	modport user (output chans, output sel, input pick);
endinterface : stm_route_if

// file: design/stm_src_mux.sv
// Routes any channel to each logical line, one registered pick per line.
// Assumes channel inputs are already synchronised to clk.
module stm_src_mux #(
	parameter int NCH = stm_pkg::NUM_CHAN,
	parameter int NSEL = stm_pkg::NUM_SRC,
	parameter int SW = stm_pkg::SRC_W
) (
	input logic clk,
	input logic rstn,
	stm_route_if.mux rt
);
	logic [NSEL-1:0] pick_next;
	logic [NSEL-1:0] pick_reg;

	// ----------------------------------------------------------------
	// Selection
	// ----------------------------------------------------------------
	// Out-of-range indices read as low rather than wrapping onto a channel
	always_comb begin
		pick_next = '0;
		for (int s = 0; s < NSEL; s++) begin
			if (rstn && (rt.sel[s] < SW'(NCH))) begin
				pick_next[s] = rt.chans[rt.sel[s]];
			end
		end
	end

	always_ff @(posedge clk) begin
		pick_reg <= pick_next;
	end

	assign rt.pick = pick_reg;

endmodule : stm_src_mux

// file: design/stm_trigger_matcher.sv
// Serial bus trigger matcher: watches I2C or SPI traffic and pulses a trigger.
// Assumes configuration ports are static around cfg_load and chan_in is asynchronous.

// Overview of operation
// RQ1: Compare I2C data: equal, greater, less
// RQ2: Qualifier only under memory frame condition
// RQ3: Memory frame: start, control, read, ack, data
// RQ4: Direction match: read, write or either
// RQ5: Address taken as seven or ten bits
// RQ6: Data byte count equals length 1..12
// RQ7: SPI bits latched on chosen clock edge
// RQ8: Framing: plain, inverted select, or timeout
// RQ9: Clock idle timeout ends the SPI frame
// RQ10: Plain framing uses the plain select source
// RQ11: Each line routed from any of 20 inputs
// RQ12: Per-bit pattern of one, zero, don't-care
// RQ13: Count bits only while select is active
// RQ14: One-cycle trigger when all criteria hold
module stm_trigger_matcher #(
	parameter int TMO_MAX_CYC = stm_pkg::TMO_MAX_CYC
) (
	input logic mclk,
	input logic rst_n,
	input logic cfg_load,
	input stm_pkg::stm_proto_t protocol_select,
	input stm_pkg::stm_cond_t i2c_condition_select,
	input stm_pkg::stm_qual_t i2c_data_compare_select,
	input stm_pkg::stm_dir_t i2c_direction_match,
	input stm_pkg::stm_awidth_t i2c_address_width_select,
	input logic [9:0] i2c_address_value,
	input logic [7:0] i2c_data_value,
	input logic [3:0] i2c_byte_count_match,
	input logic [stm_pkg::SRC_W-1:0] i2c_clock_source,
	input logic [stm_pkg::SRC_W-1:0] i2c_data_source,
	input stm_pkg::stm_edge_t spi_latch_edge_select,
	input stm_pkg::stm_frame_t spi_framing_type,
	input logic spi_data_line_select,
	input logic [stm_pkg::TMO_W-1:0] spi_clock_idle_timeout,
	input logic [stm_pkg::SPI_LEN_W-1:0] spi_data_length,
	input logic [stm_pkg::SPI_BITS-1:0] spi_bit_pattern,
	input logic [stm_pkg::SPI_BITS-1:0] spi_bit_care,
	input logic [stm_pkg::SRC_W-1:0] spi_serial_clock_source,
	input logic [stm_pkg::SRC_W-1:0] spi_host_out_source,
	input logic [stm_pkg::SRC_W-1:0] spi_host_in_source,
	input logic [stm_pkg::SRC_W-1:0] spi_plain_select_source,
	input logic [stm_pkg::SRC_W-1:0] spi_inverted_select_source,
	output logic cfg_busy,
	input logic acq_clk,
	input logic [stm_pkg::NUM_CHAN-1:0] chan_in,
	output logic trigger_pulse
);
	localparam logic [stm_pkg::TMO_W-1:0] TMO_MIN = stm_pkg::TMO_W'(stm_pkg::TMO_MIN_CYC);
	localparam logic [stm_pkg::TMO_W-1:0] TMO_MAX = stm_pkg::TMO_W'(TMO_MAX_CYC);

	// ----------------------------------------------------------------
	// Configuration handshake, mclk side
	// ----------------------------------------------------------------
	stm_pkg::stm_cfg_t snap_reg, snap_next;
	logic tgl_reg, tgl_next, pend_reg, pend_next, ack_s1_reg, ack_s2_reg;
	logic ack_tgl_reg;

	// Snapshot stays frozen while a transfer is pending, so the far side copies stable words
	always_comb begin
		snap_next = snap_reg;
		tgl_next = tgl_reg;
		pend_next = pend_reg && (ack_s2_reg != tgl_reg);
		if (!rst_n) begin
			snap_next = stm_pkg::CFG_RESET;
			tgl_next = 1'b0;
			pend_next = 1'b0;
		end else if (cfg_load && !pend_reg) begin
			snap_next.proto = protocol_select;
			snap_next.cond = i2c_condition_select;
			snap_next.qual = i2c_data_compare_select;
			snap_next.dir = i2c_direction_match;
			snap_next.awidth = i2c_address_width_select;
			snap_next.addr = i2c_address_value;
			snap_next.data = i2c_data_value;
			snap_next.dlen = i2c_byte_count_match;
			snap_next.edge_sel = spi_latch_edge_select;
			snap_next.frame = spi_framing_type;
			snap_next.line_in = spi_data_line_select;
			snap_next.tmo = (spi_clock_idle_timeout < TMO_MIN) ? TMO_MIN :
				(spi_clock_idle_timeout > TMO_MAX) ? TMO_MAX : spi_clock_idle_timeout;
			snap_next.slen = spi_data_length;
			snap_next.pat = spi_bit_pattern;
			snap_next.care = spi_bit_care;
			snap_next.src[stm_pkg::SRC_SCL] = i2c_clock_source;
			snap_next.src[stm_pkg::SRC_SDA] = i2c_data_source;
			snap_next.src[stm_pkg::SRC_SCLK] = spi_serial_clock_source;
			snap_next.src[stm_pkg::SRC_HOUT] = spi_host_out_source;
			snap_next.src[stm_pkg::SRC_HIN] = spi_host_in_source;
			snap_next.src[stm_pkg::SRC_SEL] = spi_plain_select_source;
			snap_next.src[stm_pkg::SRC_ISEL] = spi_inverted_select_source;
			tgl_next = !tgl_reg;
			pend_next = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		snap_reg <= snap_next;
		tgl_reg <= tgl_next;
		pend_reg <= pend_next;
		ack_s1_reg <= ack_tgl_reg;
		ack_s2_reg <= ack_s1_reg;
	end

	assign cfg_busy = pend_reg;

	// ----------------------------------------------------------------
	// Acquisition side: reset, input and handshake synchronisers
	// ----------------------------------------------------------------
	logic acq_rs1_reg, acq_rstn_reg, req_s1_reg, req_s2_reg;
	logic [stm_pkg::NUM_CHAN-1:0] ch_s1_reg, ch_s2_reg;
	stm_pkg::stm_cfg_t cfg_reg, cfg_next;
	logic ack_tgl_next;

	always_ff @(posedge acq_clk) begin
		acq_rs1_reg <= rst_n;
		acq_rstn_reg <= acq_rs1_reg;
		req_s1_reg <= tgl_reg;
		req_s2_reg <= req_s1_reg;
		ch_s1_reg <= chan_in;
		ch_s2_reg <= ch_s1_reg;
	end

	// Copy the snapshot once the request toggle has settled, then echo it back
	always_comb begin
		cfg_next = cfg_reg;
		ack_tgl_next = ack_tgl_reg;
		if (!acq_rstn_reg) begin
			cfg_next = stm_pkg::CFG_RESET;
			ack_tgl_next = 1'b0;
		end else if (req_s2_reg != ack_tgl_reg) begin
			cfg_next = snap_reg;
			ack_tgl_next = req_s2_reg;
		end
	end

	always_ff @(posedge acq_clk) begin
		cfg_reg <= cfg_next;
		ack_tgl_reg <= ack_tgl_next;
	end

	// ----------------------------------------------------------------
	// Source routing
	// ----------------------------------------------------------------
	stm_route_if rt ();
	assign rt.chans = ch_s2_reg;
	// RQ11 any-channel routing
	assign rt.sel = cfg_reg.src;

	stm_src_mux u_mux (
		.clk(acq_clk),
		.rstn(acq_rstn_reg),
		.rt(rt)
	);

	// ----------------------------------------------------------------
	// I2C matcher
	// ----------------------------------------------------------------
	stm_pkg::stm_i2c_state_t i2c_st_reg, i2c_st_next;
	logic scl_p_reg, sda_p_reg, rw_reg, rw_next, ctl_ack_reg, ctl_ack_next;
	logic addr_ok_reg, addr_ok_next, i2c_hit, dir_ok, qual_ok;
	logic [3:0] bit_reg, bit_next, dcnt_reg, dcnt_next;
	logic [1:0] byte_reg, byte_next;
	logic [7:0] shift_reg, shift_next;
	wire scl_s = rt.pick[stm_pkg::SRC_SCL];
	wire sda_s = rt.pick[stm_pkg::SRC_SDA];
	wire i2c_start = scl_s && scl_p_reg && sda_p_reg && !sda_s;
	wire i2c_stop = scl_s && scl_p_reg && !sda_p_reg && sda_s;
	wire i2c_rise = scl_s && !scl_p_reg;

	always_comb begin
		i2c_st_next = i2c_st_reg;
		rw_next = rw_reg;
		ctl_ack_next = ctl_ack_reg;
		addr_ok_next = addr_ok_reg;
		bit_next = bit_reg;
		dcnt_next = dcnt_reg;
		byte_next = byte_reg;
		shift_next = shift_reg;
		i2c_hit = 1'b0;
		// RQ4 direction qualification
		dir_ok = (cfg_reg.dir == stm_pkg::DIR_EITHER) ||
			((cfg_reg.dir == stm_pkg::DIR_READ) && rw_reg) ||
			((cfg_reg.dir == stm_pkg::DIR_WRITE) && !rw_reg);
		// RQ1 data qualifier
		case (cfg_reg.qual)
			stm_pkg::QUAL_GREATER: qual_ok = shift_reg > cfg_reg.data;
			stm_pkg::QUAL_LESS: qual_ok = shift_reg < cfg_reg.data;
			default: qual_ok = shift_reg == cfg_reg.data;
		endcase
		if (i2c_start || i2c_stop) begin
			// RQ6 byte count checked when the transfer ends or restarts
			if ((cfg_reg.cond == stm_pkg::COND_ADDR_LEN) && (i2c_st_reg == stm_pkg::I2C_XFER) &&
				addr_ok_reg && dir_ok && (dcnt_reg == cfg_reg.dlen)) begin
				i2c_hit = 1'b1;
			end
			i2c_st_next = i2c_start ? stm_pkg::I2C_XFER : stm_pkg::I2C_IDLE;
			bit_next = '0;
			byte_next = '0;
			dcnt_next = '0;
			addr_ok_next = 1'b0;
			ctl_ack_next = 1'b0;
		end else if (i2c_rise && (i2c_st_reg == stm_pkg::I2C_XFER)) begin
			if (bit_reg != stm_pkg::I2C_ACK_SLOT) begin
				shift_next = {shift_reg[6:0], sda_s};
				bit_next = bit_reg + 4'h1;
			end else begin
				bit_next = '0;
				byte_next = (byte_reg == stm_pkg::I2C_BYTE_SAT) ? byte_reg : byte_reg + 2'h1;
				if (byte_reg == 2'h0) begin
					rw_next = shift_reg[0];
					ctl_ack_next = !sda_s;
					// RQ5 first address byte, seven or ten bit form
					addr_ok_next = (cfg_reg.awidth == stm_pkg::ADDR_SEVEN_BIT) ?
						(shift_reg[7:1] == cfg_reg.addr[6:0]) :
						(shift_reg[7:1] == {stm_pkg::TEN_BIT_PREFIX, cfg_reg.addr[9:8]});
				end else if ((byte_reg == 2'h1) && (cfg_reg.awidth == stm_pkg::ADDR_TEN_BIT)) begin
					// RQ5 low address byte of the ten bit form
					addr_ok_next = addr_ok_reg && (shift_reg == cfg_reg.addr[7:0]);
				end else if (dcnt_reg <= 4'(stm_pkg::I2C_DLEN_MAX)) begin
					dcnt_next = dcnt_reg + 4'h1;
				end
				// RQ3 memory frame needs read bit and acked control byte
				// RQ2 qualifier used only here
				if ((cfg_reg.cond == stm_pkg::COND_MEM_FRAME) && (byte_reg == 2'h1) &&
					rw_reg && ctl_ack_reg && dir_ok && qual_ok) begin
					i2c_hit = 1'b1;
				end
			end
		end
		if (!acq_rstn_reg) begin
			i2c_st_next = stm_pkg::I2C_IDLE;
			rw_next = 1'b0;
			bit_next = '0;
			byte_next = '0;
			dcnt_next = '0;
			addr_ok_next = 1'b0;
			ctl_ack_next = 1'b0;
			shift_next = '0;
		end
	end

	always_ff @(posedge acq_clk) begin
		i2c_st_reg <= i2c_st_next;
		scl_p_reg <= scl_s;
		sda_p_reg <= sda_s;
		rw_reg <= rw_next;
		ctl_ack_reg <= ctl_ack_next;
		addr_ok_reg <= addr_ok_next;
		bit_reg <= bit_next;
		dcnt_reg <= dcnt_next;
		byte_reg <= byte_next;
		shift_reg <= shift_next;
	end

	// ----------------------------------------------------------------
	// SPI matcher
	// ----------------------------------------------------------------
	logic clk_p_reg, done_reg, done_next, spi_hit, spi_active, timed_out, sel_s;
	logic [stm_pkg::SPI_LEN_W-1:0] cnt_reg, cnt_next;
	logic [stm_pkg::TMO_W-1:0] idle_reg, idle_next;
	logic [stm_pkg::SPI_BITS-1:0] sh_reg, sh_next, len_mask;
	wire sclk_s = rt.pick[stm_pkg::SRC_SCLK];
	wire clk_chg = sclk_s != clk_p_reg;
	// RQ7 latch edge selection
	wire edge_hit = clk_chg && (sclk_s == (cfg_reg.edge_sel == stm_pkg::EDGE_RISING));
	wire data_s = cfg_reg.line_in ? rt.pick[stm_pkg::SRC_HIN] : rt.pick[stm_pkg::SRC_HOUT];

	// Idle counter saturates, so the longest timeout never wraps into a false boundary
	always_comb begin
		sh_next = sh_reg;
		cnt_next = cnt_reg;
		done_next = done_reg;
		spi_hit = 1'b0;
		idle_next = clk_chg ? '0 : ((idle_reg == '1) ? idle_reg : idle_reg + 1'b1);
		for (int i = 0; i < stm_pkg::SPI_BITS; i++) begin
			len_mask[i] = stm_pkg::SPI_LEN_W'(i) < cfg_reg.slen;
		end
		// RQ10 plain framing reads the plain select source
		sel_s = (cfg_reg.frame == stm_pkg::FRAME_INVERTED) ? rt.pick[stm_pkg::SRC_ISEL] :
			rt.pick[stm_pkg::SRC_SEL];
		// RQ9 idle interval ends the frame
		timed_out = (idle_reg >= cfg_reg.tmo) && !clk_chg;
		// RQ8 three framing types
		// RQ13 select polarity gates counting
		case (cfg_reg.frame)
			stm_pkg::FRAME_PLAIN: spi_active = sel_s;
			stm_pkg::FRAME_INVERTED: spi_active = !sel_s;
			default: spi_active = !timed_out;
		endcase
		if (!spi_active) begin
			cnt_next = '0;
			done_next = 1'b0;
		end else if (edge_hit && !done_reg) begin
			sh_next = {sh_reg[stm_pkg::SPI_BITS-2:0], data_s};
			cnt_next = cnt_reg + 1'b1;
			// RQ12 pattern with don't-care bits
			if ((cnt_next == cfg_reg.slen) &&
				(((sh_next ^ cfg_reg.pat) & cfg_reg.care & len_mask) == '0)) begin
				spi_hit = 1'b1;
			end
			done_next = (cnt_next == cfg_reg.slen) || (cnt_next == '1);
		end
		if (!acq_rstn_reg) begin
			sh_next = '0;
			cnt_next = '0;
			done_next = 1'b0;
			idle_next = '0;
		end
	end

	always_ff @(posedge acq_clk) begin
		clk_p_reg <= sclk_s;
		sh_reg <= sh_next;
		cnt_reg <= cnt_next;
		done_reg <= done_next;
		idle_reg <= idle_next;
	end

	// ----------------------------------------------------------------
	// Trigger output
	// ----------------------------------------------------------------
	logic trig_next;

	// RQ14 pulse from the selected protocol only
	always_comb begin
		trig_next = acq_rstn_reg &&
			((cfg_reg.proto == stm_pkg::PROTO_I2C) ? i2c_hit : spi_hit);
	end

	always_ff @(posedge acq_clk) begin
		trigger_pulse <= trig_next;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_trig_single: assert property (@(posedge acq_clk) disable iff (!acq_rstn_reg) // RQ14
		trigger_pulse |=> !trigger_pulse) else $error("trigger longer than one cycle");
	a_qual_equal: assert property (@(posedge acq_clk) disable iff (!acq_rstn_reg) // RQ1
		trigger_pulse && (cfg_reg.proto == stm_pkg::PROTO_I2C) &&
		(cfg_reg.cond == stm_pkg::COND_MEM_FRAME) && (cfg_reg.qual == stm_pkg::QUAL_EQUAL)
		|-> shift_reg == cfg_reg.data) else $error("equal qualifier violated");
	a_qual_greater: assert property (@(posedge acq_clk) disable iff (!acq_rstn_reg) // RQ1
		trigger_pulse && (cfg_reg.proto == stm_pkg::PROTO_I2C) &&
		(cfg_reg.cond == stm_pkg::COND_MEM_FRAME) && (cfg_reg.qual == stm_pkg::QUAL_GREATER)
		|-> shift_reg > cfg_reg.data) else $error("greater qualifier violated");
	a_dir_read: assert property (@(posedge acq_clk) disable iff (!acq_rstn_reg) // RQ4
		trigger_pulse && (cfg_reg.proto == stm_pkg::PROTO_I2C) &&
		(cfg_reg.dir == stm_pkg::DIR_READ) |-> rw_reg) else $error("read match on write");
	a_byte_count: assert property (@(posedge acq_clk) disable iff (!acq_rstn_reg) // RQ6
		trigger_pulse && (cfg_reg.proto == stm_pkg::PROTO_I2C) &&
		(cfg_reg.cond == stm_pkg::COND_ADDR_LEN) |-> $past(dcnt_reg) == $past(cfg_reg.dlen))
		else $error("byte count mismatch at trigger");
	a_plain_gate: assert property (@(posedge acq_clk) disable iff (!acq_rstn_reg) // RQ13
		(cfg_reg.frame == stm_pkg::FRAME_PLAIN) && !rt.pick[stm_pkg::SRC_SEL]
		|=> cnt_reg == '0) else $error("bits counted with plain select low");
	a_inv_gate: assert property (@(posedge acq_clk) disable iff (!acq_rstn_reg) // RQ8
		(cfg_reg.frame == stm_pkg::FRAME_INVERTED) && rt.pick[stm_pkg::SRC_ISEL]
		|=> cnt_reg == '0) else $error("bits counted with inverted select high");
	a_idle_bound: assert property (@(posedge acq_clk) disable iff (!acq_rstn_reg) // RQ9
		(cfg_reg.frame == stm_pkg::FRAME_TIMEOUT) && (idle_reg >= cfg_reg.tmo) && !clk_chg
		|=> cnt_reg == '0) else $error("timeout did not end the frame");
	a_pattern_hit: assert property (@(posedge acq_clk) disable iff (!acq_rstn_reg) // RQ12
		trigger_pulse && (cfg_reg.proto == stm_pkg::PROTO_SPI)
		|-> (((sh_reg ^ cfg_reg.pat) & cfg_reg.care & len_mask) == '0) && (cnt_reg == cfg_reg.slen))
		else $error("spi trigger without pattern match");
	a_edge_count: assert property (@(posedge acq_clk) disable iff (!acq_rstn_reg) // RQ7
		(cnt_reg != $past(cnt_reg)) && (cnt_reg != '0)
		|-> $past(edge_hit)) else $error("bit counted on wrong edge");

endmodule : stm_trigger_matcher

// file: sim/stm_bus_model.sv
// Far-side bus model: a host and target pair on I2C or SPI, driving the channel pins.
// Assumes tasks are called from the bench; channel map: SCL 4, SDA 5, SPI 6..10.
module stm_bus_model (
	input wire logic acq_clk,
	output logic [stm_pkg::NUM_CHAN-1:0] chan
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SCL = 4;
	localparam int SDA = 5;
	localparam int SCK = 6;
	localparam int HOUT = 7;
	localparam int HIN = 8;
	localparam int SEL = 9;
	localparam int ISEL = 10;

	// Pulled-up I2C lines idle high, inverted select idles high
	initial chan = 20'h00430;

	task automatic gap(input int n);
		repeat (n) @(posedge acq_clk);
	endtask : gap

	// Three acq cycles per phase keeps edges well apart for the synchronisers
	task automatic i2c_bit(input logic b);
		chan[SDA] <= b;
		gap(3);
		chan[SCL] <= 1'b1;
		gap(3);
		chan[SCL] <= 1'b0;
		gap(3);
	endtask : i2c_bit

	task automatic i2c_start();
		chan[SDA] <= 1'b1;
		gap(3);
		chan[SCL] <= 1'b1;
		gap(3);
		chan[SDA] <= 1'b0;
		gap(3);
		chan[SCL] <= 1'b0;
		gap(3);
	endtask : i2c_start

	task automatic i2c_stop();
		chan[SDA] <= 1'b0;
		gap(3);
		chan[SCL] <= 1'b1;
		gap(3);
		chan[SDA] <= 1'b1;
		gap(3);
	endtask : i2c_stop

	// Byte goes out MSB first, target acks low on the ninth clock
	task automatic i2c_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			i2c_bit(b[i]);
		end
		i2c_bit(1'b0);
	endtask : i2c_byte

	// Clock parks at its idle level for n cycles; the bench picks n to outlast the idle timeout
	task automatic spi_idle(input logic lvl, input int n);
		chan[SCK] <= lvl;
		gap(n);
	endtask : spi_idle

	// kind: 0 plain select, 1 inverted select, 2 no select at all
	task automatic spi_frame(input logic [95:0] v, input int n, input logic lvl, input int kind);
		if (kind < 2) begin
			// Stray clocks outside the frame must not be counted
			repeat (2) begin
				chan[SCK] <= ~lvl;
				gap(3);
				chan[SCK] <= lvl;
				gap(3);
			end
		end
		if (kind == 0) chan[SEL] <= 1'b1;
		if (kind == 1) chan[ISEL] <= 1'b0;
		gap(3);
		// Data flips between latch edge and the other edge to expose a wrong edge
		for (int i = n - 1; i >= 0; i--) begin
			chan[HOUT] <= v[i];
			chan[HIN] <= ~v[i];
			gap(3);
			chan[SCK] <= ~lvl;
			gap(3);
			chan[HOUT] <= ~v[i];
			chan[HIN] <= v[i];
			gap(3);
			chan[SCK] <= lvl;
			gap(3);
		end
		if (kind == 0) chan[SEL] <= 1'b0;
		if (kind == 1) chan[ISEL] <= 1'b1;
		gap(30);
	endtask : spi_frame
endmodule : stm_bus_model

// file: sim/tb_top.sv
// Self-checking bench for the trigger matcher: loads configs, plays traffic, counts pulses.
// Assumes the bus model in stm_bus_model.sv; idle timeout ceiling shortened to 200.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, acq_clk, rst_n, cfg_load, cfg_busy, trigger_pulse;
	logic [stm_pkg::NUM_CHAN-1:0] chan;
	stm_pkg::stm_cfg_t c, drv;
	int n_mismatch = 0, cmp_count = 0, n_trig = 0, base = 0, cyc = 0;
	int hit[3] = '{1, 0, 2};
	int dexp[3] = '{0, 1, 1};
	logic [7:0] dv[3] = '{8'h40, 8'h55, 8'h60};

	// ----------------------------------------------------------------
	// Clocks, design and model
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		acq_clk = 1'b0;
		#7;
		forever #32 acq_clk = ~acq_clk;
	end

	stm_trigger_matcher #(.TMO_MAX_CYC(200)) uut (
		.mclk(mclk), .rst_n(rst_n), .cfg_load(cfg_load),
		.protocol_select(drv.proto), .i2c_condition_select(drv.cond),
		.i2c_data_compare_select(drv.qual), .i2c_direction_match(drv.dir),
		.i2c_address_width_select(drv.awidth), .i2c_address_value(drv.addr),
		.i2c_data_value(drv.data), .i2c_byte_count_match(drv.dlen),
		.i2c_clock_source(drv.src[stm_pkg::SRC_SCL]),
		.i2c_data_source(drv.src[stm_pkg::SRC_SDA]),
		.spi_latch_edge_select(drv.edge_sel), .spi_framing_type(drv.frame),
		.spi_data_line_select(drv.line_in), .spi_clock_idle_timeout(drv.tmo),
		.spi_data_length(drv.slen), .spi_bit_pattern(drv.pat), .spi_bit_care(drv.care),
		.spi_serial_clock_source(drv.src[stm_pkg::SRC_SCLK]),
		.spi_host_out_source(drv.src[stm_pkg::SRC_HOUT]),
		.spi_host_in_source(drv.src[stm_pkg::SRC_HIN]),
		.spi_plain_select_source(drv.src[stm_pkg::SRC_SEL]),
		.spi_inverted_select_source(drv.src[stm_pkg::SRC_ISEL]),
		.cfg_busy(cfg_busy), .acq_clk(acq_clk), .chan_in(chan), .trigger_pulse(trigger_pulse)
	);
	stm_bus_model bus (.acq_clk(acq_clk), .chan(chan));

	// A pulse held two cycles counts twice, so counts also police the width
	// Unknown levels once reset has settled count as pulses, so they cannot slip past
	always @(posedge acq_clk) if (cyc > 4 && trigger_pulse !== 1'b0) n_trig <= n_trig + 1;
	// Hang guard: the run needs about 6000 mclk cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict

	// Loads the shadow config; busy must rise, then fall within a bounded wait
	task automatic load();
		int k;
		k = 0;
		@(posedge mclk);
		drv <= c;
		cfg_load <= 1'b1;
		@(posedge mclk);
		cfg_load <= 1'b0;
		@(posedge mclk);
		#1 check("busy_set", cfg_busy, 1);
		while (cfg_busy !== 1'b0 && k < 40) begin
			@(posedge mclk);
			k++;
		end
		check("busy_clr", cfg_busy, 0);
		repeat (6) @(posedge acq_clk);
	endtask : load

	task automatic expect_trig(input string nm, input int exp);
		repeat (12) @(posedge acq_clk);
		check(nm, n_trig - base, exp);
		base = n_trig;
	endtask : expect_trig

	task automatic xfer(input logic [7:0] a0, input logic [7:0] a1, input bit two, input int nb);
		bus.i2c_start();
		bus.i2c_byte(a0);
		if (two) bus.i2c_byte(a1);
		repeat (nb) bus.i2c_byte(8'h55);
		bus.i2c_stop();
	endtask : xfer

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		cfg_load = 1'b0;
		c = '0;
		drv = '0;
		// Two mclk cycles span two acq edges, enough for the reset synchroniser
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (6) @(posedge acq_clk);
		check("busy_rst", cfg_busy, 0);
		check("trig_rst", n_trig, 0);
		c.src = {5'h0a, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04};
		c.dir = stm_pkg::DIR_EITHER;
		// every qualifier against below, equal and above
		for (int q = 0; q < 3; q++) begin
			for (int j = 0; j < 3; j++) begin
				c.qual = stm_pkg::stm_qual_t'(q);
				c.data = dv[j];
				load();
				xfer(8'ha1, 8'h00, 0, 1);
				expect_trig("mem_qual", int'(j == hit[q]));
			end
		end
		xfer(8'ha0, 8'h00, 0, 1);
		expect_trig("mem_write", 0);
		// qualifier set to never-true, yet length match fires
		c.cond = stm_pkg::COND_ADDR_LEN;
		c.qual = stm_pkg::QUAL_LESS;
		c.data = 8'h00;
		c.addr = 10'h03a;
		c.dlen = 4'h3;
		for (int d = 0; d < 3; d++) begin
			c.dir = stm_pkg::stm_dir_t'(d);
			load();
			xfer(8'h74, 8'h00, 0, 3);
			expect_trig("dir", dexp[d]);
			// Same address as a read: matches read and either, not write
			xfer(8'h75, 8'h00, 0, 3);
			expect_trig("dir_rd", int'(d != 1));
		end
		xfer(8'h74, 8'h00, 0, 2);
		expect_trig("len_short", 0);
		c.dlen = 4'hc;
		load();
		xfer(8'h74, 8'h00, 0, 12);
		expect_trig("len_max", 1);
		c.awidth = stm_pkg::ADDR_TEN_BIT;
		c.addr = 10'h122;
		c.dlen = 4'h1;
		load();
		xfer(8'hf2, 8'h22, 1, 1);
		expect_trig("ten_bit", 1);
		c.awidth = stm_pkg::ADDR_SEVEN_BIT;
		load();
		xfer(8'hf2, 8'h22, 1, 1);
		expect_trig("seven_bit", 0);
		// all framings on both latch edges, top nibble cared
		c.proto = stm_pkg::PROTO_SPI;
		c.slen = 7'h08;
		c.pat = 96'ha0;
		c.care = 96'hf0;
		c.tmo = 17'h0000a;
		for (int f = 0; f < 3; f++) begin
			for (int e = 0; e < 2; e++) begin
				c.frame = stm_pkg::stm_frame_t'(f);
				c.edge_sel = stm_pkg::stm_edge_t'(e);
				load();
				bus.spi_idle(e[0], 30);
				bus.spi_frame(96'ha5, 8, e[0], f);
				expect_trig("spi_frame", 1);
			end
		end
		// two half frames split by a gap longer than the timeout
		bus.spi_frame(96'ha, 4, 1'b1, 2);
		bus.spi_frame(96'h5, 4, 1'b1, 2);
		expect_trig("tmo_split", 0);
		c.tmo = 17'h000c8;
		load();
		bus.spi_idle(1'b1, 250);
		bus.spi_frame(96'ha, 4, 1'b1, 2);
		bus.spi_frame(96'h5, 4, 1'b1, 2);
		expect_trig("tmo_join", 1);
		c.frame = stm_pkg::FRAME_PLAIN;
		c.care = 96'hff;
		load();
		bus.spi_frame(96'ha5, 8, 1'b1, 0);
		expect_trig("care_all", 0);
		c.pat = 96'h5a;
		c.line_in = 1'b1;
		load();
		bus.spi_frame(96'ha5, 8, 1'b1, 0);
		expect_trig("host_in", 1);
		print_verdict();
	end
endmodule : tb_top
